// file: rtl/otp_prog_pkg.sv
// Constants and pin bundle for the one-time-programmable memory programmer
package otp_prog_pkg;
   // ----------------------------------------
   // Memory geometry
   // ----------------------------------------
   localparam int ROM_ADDR_W = 18;
   localparam int ROM_DATA_W = 8;
   localparam int TMR_W = 12;
   localparam logic [3:0] MAX_RETRY = 4'hA;   // Extra pulses allowed per byte
   localparam logic [ROM_ADDR_W-1:0] ADDR_ZERO = 18'h00000;
   localparam logic [ROM_ADDR_W-1:0] ADDR_LAST_DEF = 18'h3FFFF;

   // ----------------------------------------
   // Timing, in ns and in 40 MHz cycles
   // ----------------------------------------
   localparam int CLK_NS = 25;
   localparam int T_PW_NS = 100000;    // Nominal program pulse, 95..105 us allowed
   localparam int T_SETUP_NS = 2000;   // Address, data, strobe and supply setup/hold
   localparam int T_DFP_NS = 130;      // Output float after output enable rises
   localparam logic [TMR_W-1:0] PW_CYC = TMR_W'(T_PW_NS / CLK_NS);
   localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] FLOAT_CYC = TMR_W'((T_DFP_NS + CLK_NS - 1) / CLK_NS);

   // ----------------------------------------
   // Pins driven toward the memory
   // ----------------------------------------
   typedef struct packed {
      logic [ROM_ADDR_W-1:0] addr;
      logic [ROM_DATA_W-1:0] data_out;
      logic data_oe;              // High while the programmer drives the data pins
      logic chip_sel_n;
      logic out_en_n;
      logic program_strobe_n;
      logic vcc_prog;             // High selects 6.5 V core supply, low 5.0 V
      logic vpp_prog;             // High selects 13.0 V programming supply, low 5.0 V
      logic id_hv;                // High lifts address_bit_nine to the id voltage
   } rom_pins_t;

   localparam rom_pins_t PINS_IDLE = '{addr: ADDR_ZERO, data_out: 8'h00, data_oe: 1'b0,
      chip_sel_n: 1'b1, out_en_n: 1'b1, program_strobe_n: 1'b1, vcc_prog: 1'b0,
      vpp_prog: 1'b0, id_hv: 1'b0};
endpackage

// file: rtl/otp_step_timer.sv
// Down-counting step timer that paces every phase of the programmer
`timescale 1ns/10ps
module otp_step_timer
   import otp_prog_pkg::*;
#(
   parameter int W = TMR_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;

   // Load with count-1 so done is seen exactly count cycles after the load edge
   always_comb begin
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      if (load) begin
         cnt_next = count - W'(1);
         busy_next = 1'b1;
      end else if (busy_reg && cnt_reg != '0) begin
         cnt_next = cnt_reg - W'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
      end
   end

   assign done = busy_reg && cnt_reg == '0;
endmodule

// file: rtl/otp_programmer.sv
// Programmer sequencer: rapid programming run, read-back check and id read
// Contract
// - Each program strobe pulse lasts 100 us, within 95 to 105 us.
// - Address starts at the first location before any pulse.
// - Core supply at 6.5 V and programming supply at 13.0 V first.
// - First pass gives each address one pulse, no verify reads.
// - Verify-and-reprogram loop then restarts from the first address.
// - Failing byte gets at most 10 extra pulses, verify after each.
// - Still mismatching after the tenth extra pulse aborts the run as failed.
// - Verified byte advances the address until the whole range is checked.
// - After the verify loop both supplies return to 5.0 V.
// - At nominal supply read every byte; pass only if all match.
// - Id mode needs address_bit_nine held at the id voltage.
`timescale 1ns/10ps
module otp_programmer
   import otp_prog_pkg::*;
#(
   parameter logic [ROM_ADDR_W-1:0] LAST_ADDR = ADDR_LAST_DEF
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic start,
   input wire logic id_req,
   input wire logic [ROM_DATA_W-1:0] src_data,
   input wire logic [ROM_DATA_W-1:0] data_outputs,
   output rom_pins_t pins,
   output logic [ROM_ADDR_W-1:0] src_addr,
   output logic busy,
   output logic done,
   output logic pass,
   output logic fail,
   output logic id_valid,
   output logic [ROM_DATA_W-1:0] maker_code,
   output logic [ROM_DATA_W-1:0] device_code
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_SUPPLY, S_PSET, S_PULSE, S_PHOLD, S_VREAD, S_VFLOAT,
      S_SUPDN, S_RREAD, S_RFLOAT, S_ID0, S_ID1
   } state_t;

   state_t state_reg, state_next;
   rom_pins_t pins_reg, pins_next;
   logic [3:0] retry_reg, retry_next;
   logic verify_reg, verify_next;
   logic match_reg, match_next;
   logic mism_reg, mism_next;
   logic busy_reg, busy_next, done_reg, done_next, pass_reg, pass_next;
   logic fail_reg, fail_next, idv_reg, idv_next;
   logic [ROM_DATA_W-1:0] maker_reg, maker_next, dev_reg, dev_next;
   logic tmr_load, tmr_done;
   logic [TMR_W-1:0] tmr_count;
   logic is_last;

   assign is_last = pins_reg.addr == LAST_ADDR;

   otp_step_timer #(.W(TMR_W)) u_timer (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );

   // ----------------------------------------
   // Sequencer next-state logic
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      pins_next = pins_reg;
      retry_next = retry_reg;
      verify_next = verify_reg;
      match_next = match_reg;
      mism_next = mism_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      pass_next = pass_reg;
      fail_next = fail_reg;
      idv_next = 1'b0;
      maker_next = maker_reg;
      dev_next = dev_reg;
      tmr_load = 1'b0;
      tmr_count = SETUP_CYC;
      unique case (state_reg)
         S_IDLE: begin
            if (start) begin
               pins_next = PINS_IDLE;
               pins_next.vcc_prog = 1'b1;
               pins_next.vpp_prog = 1'b1;
               {verify_next, retry_next, mism_next} = '0;
               {busy_next, pass_next, fail_next} = 3'b100;
               tmr_load = 1'b1;
               state_next = S_SUPPLY;
            end else if (id_req) begin
               // id voltage; maker code with bit zero low
               pins_next = PINS_IDLE;
               pins_next.id_hv = 1'b1;
               pins_next.chip_sel_n = 1'b0;
               pins_next.out_en_n = 1'b0;
               busy_next = 1'b1;
               tmr_load = 1'b1;
               state_next = S_ID0;
            end
         end
         S_SUPPLY: begin
            if (tmr_done) begin
               pins_next.chip_sel_n = 1'b0;
               pins_next.data_oe = 1'b1;
               tmr_load = 1'b1;
               state_next = S_PSET;
            end
         end
         S_PSET: begin
            // Data follows the source until the strobe falls, then is frozen
            pins_next.data_out = src_data;
            if (tmr_done) begin
               // open a pulse of nominal width
               pins_next.program_strobe_n = 1'b0;
               tmr_count = PW_CYC;
               tmr_load = 1'b1;
               state_next = S_PULSE;
            end
         end
         S_PULSE: begin
            if (tmr_done) begin
               pins_next.program_strobe_n = 1'b1;
               tmr_load = 1'b1;
               state_next = S_PHOLD;
            end
         end
         S_PHOLD: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               pins_next.data_oe = 1'b0;
               if (verify_reg) begin
                  pins_next.out_en_n = 1'b0;
                  state_next = S_VREAD;
               end else if (is_last) begin
                  // verify loop restarts at the first address
                  pins_next.addr = ADDR_ZERO;
                  pins_next.out_en_n = 1'b0;
                  verify_next = 1'b1;
                  retry_next = '0;
                  state_next = S_VREAD;
               end else begin
                  // next address gets its single pulse, no read between
                  pins_next.addr = pins_reg.addr + 18'h00001;
                  pins_next.data_oe = 1'b1;
                  state_next = S_PSET;
               end
            end
         end
         S_VREAD: begin
            if (tmr_done) begin
               // compare the stored byte with the intended one
               match_next = data_outputs == src_data;
               pins_next.out_en_n = 1'b1;
               tmr_count = FLOAT_CYC;
               tmr_load = 1'b1;
               state_next = S_VFLOAT;
            end
         end
         S_VFLOAT: begin
            if (tmr_done) begin
               if (match_reg && is_last) begin
                  // supplies back to 5.0 V once every byte verified
                  pins_next.vcc_prog = 1'b0;
                  pins_next.vpp_prog = 1'b0;
                  pins_next.chip_sel_n = 1'b1;
                  pins_next.addr = ADDR_ZERO;
                  tmr_load = 1'b1;
                  state_next = S_SUPDN;
               end else if (match_reg) begin
                  pins_next.addr = pins_reg.addr + 18'h00001;
                  pins_next.out_en_n = 1'b0;
                  retry_next = '0;
                  tmr_load = 1'b1;
                  state_next = S_VREAD;
               end else if (retry_reg == MAX_RETRY) begin
                  pins_next = PINS_IDLE;
                  pins_next.addr = pins_reg.addr;
                  {busy_next, done_next, fail_next} = 3'b011;
                  state_next = S_IDLE;
               end else begin
                  // one more pulse for this byte
                  retry_next = retry_reg + 4'h1;
                  pins_next.data_oe = 1'b1;
                  tmr_load = 1'b1;
                  state_next = S_PSET;
               end
            end
         end
         S_SUPDN: begin
            if (tmr_done) begin
               pins_next.chip_sel_n = 1'b0;
               pins_next.out_en_n = 1'b0;
               tmr_load = 1'b1;
               state_next = S_RREAD;
            end
         end
         S_RREAD: begin
            if (tmr_done) begin
               if (data_outputs != src_data) begin
                  mism_next = 1'b1;
               end
               pins_next.out_en_n = 1'b1;
               tmr_count = FLOAT_CYC;
               tmr_load = 1'b1;
               state_next = S_RFLOAT;
            end
         end
         S_RFLOAT: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (is_last) begin
                  // pass only when no byte differed
                  pins_next = PINS_IDLE;
                  {busy_next, done_next} = 2'b01;
                  pass_next = !mism_reg;
                  fail_next = mism_reg;
                  state_next = S_IDLE;
               end else begin
                  pins_next.addr = pins_reg.addr + 18'h00001;
                  pins_next.out_en_n = 1'b0;
                  state_next = S_RREAD;
               end
            end
         end
         S_ID0: begin
            if (tmr_done) begin
               // device-type code with bit zero high
               maker_next = data_outputs;
               pins_next.addr[0] = 1'b1;
               tmr_load = 1'b1;
               state_next = S_ID1;
            end
         end
         S_ID1: begin
            if (tmr_done) begin
               dev_next = data_outputs;
               pins_next = PINS_IDLE;
               busy_next = 1'b0;
               idv_next = 1'b1;
               state_next = S_IDLE;
            end
         end
      endcase
   end

   // Register everything; every output leaves from here
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= S_IDLE;
         pins_reg <= PINS_IDLE;
         retry_reg <= 4'h0;
         {verify_reg, match_reg, mism_reg} <= 3'b000;
         {busy_reg, done_reg, pass_reg, fail_reg, idv_reg} <= 5'b00000;
         maker_reg <= 8'h00;
         dev_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         pins_reg <= pins_next;
         retry_reg <= retry_next;
         {verify_reg, match_reg, mism_reg} <= {verify_next, match_next, mism_next};
         {busy_reg, done_reg, pass_reg, fail_reg, idv_reg} <=
            {busy_next, done_next, pass_next, fail_next, idv_next};
         maker_reg <= maker_next;
         dev_reg <= dev_next;
      end
   end

   assign pins = pins_reg;
   assign src_addr = pins_reg.addr;
   assign {busy, done, pass, fail, id_valid} =
      {busy_reg, done_reg, pass_reg, fail_reg, idv_reg};
   assign maker_code = maker_reg;
   assign device_code = dev_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Helper: length of the current strobe low time
   logic [TMR_W-1:0] low_cnt;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_cnt <= '0;
      end else begin
         low_cnt <= pins_reg.program_strobe_n ? '0 : low_cnt + TMR_W'(1);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence pulse_end;
      $rose(pins_reg.program_strobe_n);
   endsequence
   sequence read_open;
      !pins_reg.out_en_n && !pins_reg.chip_sel_n && pins_reg.program_strobe_n;
   endsequence

   a_pulse_width: assert property (pulse_end |-> low_cnt == PW_CYC)
      else $error("program pulse width wrong");
   a_start_addr: assert property (state_reg == S_SUPPLY |-> pins_reg.addr == ADDR_ZERO)
      else $error("run did not start at first address");
   a_prog_supply: assert property (!pins_reg.program_strobe_n |->
      pins_reg.vcc_prog && pins_reg.vpp_prog)
      else $error("pulse without programming supplies");
   a_first_no_read: assert property (!verify_reg && busy_reg && !pins_reg.id_hv
      && (state_reg inside {S_PSET, S_PULSE, S_PHOLD}) |-> pins_reg.out_en_n)
      else $error("read during first pass");
   a_verify_restart: assert property ($rose(verify_reg) |-> pins_reg.addr == ADDR_ZERO)
      else $error("verify loop not at first address");
   a_retry_verify: assert property (verify_reg and pulse_end |->
      ##[1:120] read_open)
      else $error("no verify read after extra pulse");
   a_retry_limit: assert property (retry_reg <= MAX_RETRY)
      else $error("too many extra pulses");
   a_fail_limit: assert property ($rose(fail_reg) && state_reg == S_IDLE &&
      !pins_reg.vcc_prog && $past(verify_reg) |-> $past(retry_reg) == MAX_RETRY
      || $past(state_reg) == S_RFLOAT)
      else $error("failure reported before the last pulse");
   a_nominal_read: assert property (state_reg inside {S_SUPDN, S_RREAD, S_RFLOAT} |->
      !pins_reg.vcc_prog && !pins_reg.vpp_prog)
      else $error("read-back not at nominal supply");
   a_pass_clean: assert property ($rose(pass_reg) |-> !mism_reg && done_reg)
      else $error("pass with a mismatch");
   a_id_voltage: assert property (state_reg inside {S_ID0, S_ID1} |->
      pins_reg.id_hv && pins_reg.addr[0] == (state_reg == S_ID1))
      else $error("id read without id voltage");
   a_pulse_stable: assert property (!pins_reg.program_strobe_n |=>
      $stable(pins_reg.addr) && $stable(pins_reg.data_out) && pins_reg.data_oe)
      else $error("address or data moved during pulse");
   a_bus_release: assert property (!pins_reg.out_en_n |-> !pins_reg.data_oe)
      else $error("data driven during a read");
endmodule

// file: verif/otp_rom_model.sv
// Behavioural model of the one-time-programmable memory seen by the programmer
`timescale 1ns/10ps
module otp_rom_model
   import otp_prog_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h5A,   // Arbitrary value, not a real maker
   parameter logic [7:0] DEVICE_ID = 8'hC3   // Arbitrary value, not a real part
) (
   input wire logic clk_sys,
   input wire logic erase,
   input rom_pins_t pins,
   output logic [ROM_DATA_W-1:0] data_drive,
   output logic [7:0] viol_count
);
   logic [7:0] mem [4];
   int need [4];
   int pulses [4];
   logic [19:0] log_q [$];
   int pw;
   rom_pins_t prev;
   logic [7:0] last_out;
   logic drive_on;
   logic [7:0] stored;

   initial begin
      viol_count = 8'h00;
      pw = 0;
      prev = PINS_IDLE;
      last_out = 8'h00;
   end

   assign drive_on = !pins.chip_sel_n && !pins.out_en_n && pins.program_strobe_n;
   assign stored = pins.id_hv ? (pins.addr[0] ? DEVICE_ID : MAKER_ID) : mem[pins.addr[1:0]];
   // Released pins show the inverse of the last value so a stale byte never passes
   assign data_drive = drive_on ? stored : ~last_out;

   // Cell programming, pin checks and event log
   always @(posedge clk_sys) begin
      if (erase) begin
         foreach (mem[i]) begin
            mem[i] = 8'hFF;
            need[i] = 1;
            pulses[i] = 0;
         end
         log_q.delete();
      end
      if (!pins.chip_sel_n && !pins.program_strobe_n) begin
         pw++;
         if (!pins.vcc_prog || !pins.vpp_prog || !pins.data_oe) viol_count++;
         if (pw > 1 && (pins.addr !== prev.addr || pins.data_out !== prev.data_out)) viol_count++;
      end else if (pw > 0) begin
         if (pw < 3800 || pw > 4200) viol_count++;
         pulses[prev.addr[1:0]]++;
         // A weak cell takes need pulses before it holds its zeros
         if (pulses[prev.addr[1:0]] >= need[prev.addr[1:0]]) begin
            mem[prev.addr[1:0]] = mem[prev.addr[1:0]] & prev.data_out;
         end
         log_q.push_back({2'h1, prev.addr});
         pw = 0;
      end
      if (drive_on && prev.out_en_n && !pins.id_hv) begin
         log_q.push_back({(pins.vcc_prog ? 2'h2 : 2'h3), pins.addr});
      end
      if (!pins.out_en_n && pins.data_oe) viol_count++;
      if (drive_on) last_out = data_drive;
      prev = pins;
   end
endmodule

// file: verif/testbench.sv
// Self-checking bench for the programmer sequencer against the memory model
`timescale 1ns/10ps
module testbench;
   import otp_prog_pkg::*;
   localparam logic [ROM_ADDR_W-1:0] LAST = 18'h00003;
   localparam logic [7:0] MAKER = 8'h5A;   // Arbitrary value
   localparam logic [7:0] DEVICE = 8'hC3;  // Arbitrary value
   localparam int MAX_CYC = 100000;
   typedef struct packed {
      logic is_id;
      logic pass;
      logic fail;
      logic [7:0] maker;
      logic [7:0] device;
   } note_t;
   logic clk_sys, rst, start, id_req, erase;
   logic [7:0] src_data, data_outputs, drv, maker_code, device_code, viol;
   logic busy, done, pass, fail, id_valid;
   rom_pins_t pins;
   logic [ROM_ADDR_W-1:0] src_addr;
   logic [7:0] src_tab [4];
   note_t notes [$];
   note_t mon_note;
   logic [19:0] exp_log [$];
   int failures, tests_run, cyc, seed_dummy;

   // ----------------------------------------
   // Device, model and wire
   // ----------------------------------------
   otp_programmer #(.LAST_ADDR(LAST)) dut (.clk_sys(clk_sys), .rst(rst), .start(start),
      .id_req(id_req), .src_data(src_data), .data_outputs(data_outputs), .pins(pins),
      .src_addr(src_addr), .busy(busy), .done(done), .pass(pass), .fail(fail),
      .id_valid(id_valid), .maker_code(maker_code), .device_code(device_code));
   otp_rom_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) mem_model (.clk_sys(clk_sys),
      .erase(erase), .pins(pins), .data_drive(drv), .viol_count(viol));
   assign data_outputs = pins.data_oe ? pins.data_out : drv;

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Source bytes follow the requested address one cycle later
   always @(posedge clk_sys) src_data <= src_tab[src_addr[1:0]];

   task automatic check(input logic ok, input string msg);
      tests_run++;
      // An unknown outcome counts as a mismatch, never as a silent pass
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard sized above the longest expected run
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc >= MAX_CYC) begin
         check(1'b0, "timeout");
         finish_test();
      end
   end

   // Result watcher takes the oldest note for every completion pulse
   always @(posedge clk_sys) begin
      if (done === 1'b1 || id_valid === 1'b1) begin
         if (notes.size() == 0) check(1'b0, "unexpected completion");
         else begin
            mon_note = notes.pop_front();
            check(id_valid === mon_note.is_id && done === !mon_note.is_id, "result kind");
            if (mon_note.is_id) begin
               check(maker_code === mon_note.maker && device_code === mon_note.device, "id codes");
            end else begin
               check(pass === mon_note.pass && fail === mon_note.fail, "verdict");
            end
         end
      end
   end

   task automatic push_exp(input logic [1:0] k, input int a);
      exp_log.push_back({k, 18'(a)});
   endtask

   task automatic check_log();
      check(mem_model.log_q.size() == exp_log.size(), "event count");
      foreach (exp_log[i]) begin
         if (i < mem_model.log_q.size()) begin
            check(mem_model.log_q[i] === exp_log[i], "event order");
         end
      end
      exp_log.delete();
   endtask

   task automatic wipe();
      erase <= 1'b1;
      @(posedge clk_sys);
      erase <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic run_id();
      notes.push_back('{is_id: 1'b1, pass: 1'b0, fail: 1'b0, maker: MAKER, device: DEVICE});
      id_req <= 1'b1;
      @(posedge clk_sys);
      id_req <= 1'b0;
      @(posedge clk_sys);
      while (busy !== 1'b0) @(posedge clk_sys);
   endtask

   // Run with a refused request part way through
   task automatic do_run(input logic exp_pass);
      notes.push_back('{is_id: 1'b0, pass: exp_pass, fail: !exp_pass, maker: 8'h00,
         device: 8'h00});
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (200) @(posedge clk_sys);
      start <= 1'b1;
      id_req <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      id_req <= 1'b0;
      while (busy !== 1'b0) @(posedge clk_sys);
      @(posedge clk_sys);
      check(busy === 1'b0 && pins.vcc_prog === 1'b0 && pins.vpp_prog === 1'b0, "supplies");
      check(pins.chip_sel_n === 1'b1 && notes.size() == 0, "idle after run");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      start = 1'b0;
      id_req = 1'b0;
      erase = 1'b0;
      failures = 0;
      tests_run = 0;
      seed_dummy = $urandom(32'hBD31);
      // Clear the top bit so an unprogrammed cell always fails verify
      foreach (src_tab[i]) src_tab[i] = 8'($urandom) & 8'h7F;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      wipe();
      run_id();
      run_id();
      // One weak cell needs one extra pulse
      mem_model.need[1] = 2;
      for (int a = 0; a < 4; a++) push_exp(2'h1, a);
      push_exp(2'h2, 0);
      push_exp(2'h2, 1);
      push_exp(2'h1, 1);
      for (int a = 1; a < 4; a++) push_exp(2'h2, a);
      for (int a = 0; a < 4; a++) push_exp(2'h3, a);
      do_run(1'b1);
      check_log();
      foreach (src_tab[i]) check(mem_model.mem[i] === src_tab[i], "stored byte");
      // A cell that never takes exhausts the retries
      wipe();
      mem_model.need[0] = 12;
      for (int a = 0; a < 4; a++) push_exp(2'h1, a);
      push_exp(2'h2, 0);
      repeat (10) begin
         push_exp(2'h1, 0);
         push_exp(2'h2, 0);
      end
      do_run(1'b0);
      check_log();
      check(viol === 8'h00, "pin timing");
      finish_test();
   end
endmodule
